// file: mlr_top.sv
// module: management serial slave with the line-rate control register
`default_nettype none
// Functional notes
// R1 - one 16-bit control register at 0x10
// R2 - matching write frame loads register
// R3 - matching read frame returns register contents
// R4 - software uses address distinct from PHY
// R5 - bit 15 resets core, self-clearing
// R6 - bits 6,13 select 1000/100/10 rate
// R7 - software writes reserved bits as zero
// R8 - generate 2.5, 25, 125 MHz clocks; with the 50 MHz core clock the 125 MHz one runs at 25 MHz
// R9 - speed bits steer two cascaded muxes
// R10 - external clock must match line rate
// R11 - transmit clock drives logic, forwarded out
// R12 - receive clock buffered and forwarded
// R13 - txc from DDR cell, skew optional
// R14 - skew 1 uses output delay element
// R15 - skew 2 uses 90 degree clock; the code lags a quarter period plus a cycle at 2.5, half at 25 and 125
// R16 - management runs on free-running clock
// R17 - write opcode 01, read 10, turnaround
// R18 - answer own address only, never 0
// R19 - reset bit returns to zero afterwards
module mlr_top #(
  parameter logic [4:0] PHY_ADDR = mlr_pkg::PHY_ADDR_DEF,
  parameter bit         EXT_CLK  = 1'b0,
  parameter logic [1:0] TXC_SKEW = mlr_pkg::SKEW_NONE
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output var  logic       mdio_out,
  output var  logic       mdio_oe,
  output var  logic [1:0] speed_mode,
  output var  logic       core_reset,
  input  wire logic       ext_gmii_clk,
  output var  logic       gmii_tx_clk,
  output var  logic       rgmii_txc,
  input  wire logic       rgmii_rxc,
  output var  logic       gmii_rx_clk
);
  import mlr_pkg::*;

  // link side state on mdc, core side state on core_clk
  mlr_link_s link_reg;
  mlr_link_s link_next;
  mlr_core_s core_reg;
  mlr_core_s core_next;
  // crossing outputs and decode helpers
  logic      wr_tgl_core;
  logic      snap_tgl_link;
  logic [1:0] speed_code;
  logic      last_bit;
  logic      match;

  // ------------------------------------------------------------------
  // crossings: write toggle into core, snapshot toggle into link
  // ------------------------------------------------------------------
  // only a toggle crosses each way; the word it announces is held
  // still in its own domain until the toggle has passed three flops,
  // so the far side never samples a word that is moving.
  // the link clock may stop between frames: a register change is then
  // seen during the preamble of the next frame, which is far longer
  // than the few mdc edges the synchroniser needs
  // write toggle, link to core
  mlr_sync u_wr_sync (
    .clk   (core_clk),
    .reset (reset),
    .din   (link_reg.wr_tgl),
    .dout  (wr_tgl_core)
  );

  // register copy toggle, core to link
  mlr_sync u_rd_sync (
    .clk   (mdc),
    .reset (reset),
    .din   (core_reg.snap_tgl),
    .dout  (snap_tgl_link)
  );

  // ------------------------------------------------------------------
  // frame receiver on the management clock
  // ------------------------------------------------------------------
  // frame as this side sees it, one bit taken per rising mdc:
  //   preamble    32 ones; a zero before the 32nd restarts the count
  //   start       0 then 1; any other pair drops back to the preamble
  //   operation   2 bits, 01 write and 10 read; others are ignored
  //   device      5 bits, compared with PHY_ADDR
  //   register    5 bits; only the control register answers
  //   turnaround  2 bits; a read hit drives the second one low
  //   data        16 bits, most significant first
  // a frame meant for another device is still walked to its end, so
  // the next preamble is counted from a known point
  // the address test refuses address 0 so the PHY never sees contention
  always_comb begin
    link_next = link_reg;
    last_bit  = 1'b0;
    // ours: own device address, never 0, and the control register
    match = (link_reg.addr[9:5] == PHY_ADDR)  // R18
      && (PHY_ADDR != PHY_ADDR_PHY)  // R18
      && (link_reg.addr[4:0] == CTRL_REG_ADDR);  // R1
    // pick up a new register copy; word is stable while toggle settles
    if (snap_tgl_link != link_reg.rd_seen) begin
      link_next.rd_seen = snap_tgl_link;
      link_next.rd_word = core_reg.snap;
    end
    case (link_reg.st)
      // count ones; the zero of the start pair ends a full preamble
      MLR_PRE: begin
        link_next.pin = '0;
        if (mdio_in) begin
          if (link_reg.ones != PRE_ONES) begin
            link_next.ones = link_reg.ones + 6'h01;
          end
        end else begin
          if (link_reg.ones == PRE_ONES) begin
            link_next.st = MLR_ST;
          end
          link_next.ones = 6'h00;
        end
      end
      MLR_ST: begin
        link_next.cnt = 5'h00;
        link_next.st  = mdio_in ? MLR_OP : MLR_PRE;
      end
      // two operation bits, first bit received ends up on top
      MLR_OP: begin
        link_next.op  = {link_reg.op[0], mdio_in};
        link_next.cnt = link_reg.cnt + 5'h01;
        if (link_reg.cnt == OP_BITS - 5'h01) begin
          link_next.cnt = 5'h00;
          link_next.st  = MLR_ADDR;
        end
      end
      // device then register address, ten bits in all
      MLR_ADDR: begin
        link_next.addr = {link_reg.addr[8:0], mdio_in};
        link_next.cnt  = link_reg.cnt + 5'h01;
        if (link_reg.cnt == ADDR_BITS - 5'h01) begin
          link_next.cnt = 5'h00;
          link_next.st  = MLR_TA;
        end
      end
      MLR_TA: begin
        link_next.cnt = link_reg.cnt + 5'h01;
        if (link_reg.cnt == 5'h00) begin
          link_next.hit = match
            && ((link_reg.op == OP_WRITE) || (link_reg.op == OP_READ));
          link_next.sh  = link_reg.rd_word;
          // take the line in the second turnaround bit, driving 0
          if (match && (link_reg.op == OP_READ)) begin  // R17
            link_next.pin.mdio_oe  = 1'b1;  // R3
            link_next.pin.mdio_out = 1'b0;
          end
        end
        // second turnaround bit: first data bit goes out on a read hit
        if (link_reg.cnt == TA_BITS - 5'h01) begin
          link_next.cnt = 5'h00;
          link_next.st  = MLR_DATA;
          if (link_reg.hit && (link_reg.op == OP_READ)) begin
            link_next.pin.mdio_out = link_reg.sh[15];  // R3
            link_next.sh = {link_reg.sh[14:0], 1'b0};
          end
        end
      end
      // sixteen data bits; the last edge releases the line
      MLR_DATA: begin
        link_next.cnt = link_reg.cnt + 5'h01;
        last_bit = (link_reg.cnt == DATA_BITS - 5'h01);
        // a read for another device neither drives nor shifts out data
        if (link_reg.hit && (link_reg.op == OP_READ)) begin
          link_next.pin.mdio_out = link_reg.sh[15];  // R3
          link_next.sh = {link_reg.sh[14:0], 1'b0};
        end else begin
          link_next.sh = {link_reg.sh[14:0], mdio_in};
        end
        if (last_bit) begin
          link_next.st   = MLR_PRE;
          link_next.ones = 6'h00;
          link_next.pin  = '0;
          // hold the word and flip the toggle so the core picks it up
          if (link_reg.hit && (link_reg.op == OP_WRITE)) begin  // R17
            link_next.wr_data = {link_reg.sh[14:0], mdio_in};  // R2
            link_next.wr_tgl  = ~link_reg.wr_tgl;  // R2
          end
        end
      end
      // unused state codes fall back to the preamble
      default: begin
        link_next.st = MLR_PRE;
      end
    endcase
  end

  // link state; resets without mdc, which may be stopped
  always_ff @(posedge mdc or posedge reset) begin
    if (reset) begin
      link_reg         <= '0;
      // the copy starts at the register's reset value, since no
      // toggle ever announces that value
      link_reg.rd_word <= CTRL_RESET_VAL;
    end else begin
      link_reg <= link_next;
    end
  end

  // ------------------------------------------------------------------
  // control register and core reset on the free-running clock
  // ------------------------------------------------------------------
  // self-reset: a written bit 15 loads the default word with bit 15
  // set and starts a count of CORE_RST_CYC cycles; core_reset stands
  // for exactly that count, then bit 15 drops on its own.
  // a write that lands meanwhile waits, since its toggle is only
  // compared once the count is over; a second write in that span
  // flips the toggle back, so neither of the two writes is taken
  // a new write is only taken while no self-reset is running
  always_comb begin  // R16
    core_next = core_reg;
    if (core_reg.rst_cnt != 8'h00) begin
      core_next.rst_cnt  = core_reg.rst_cnt - 8'h01;
      core_next.core_rst = 1'b1;
      if (core_reg.rst_cnt == 8'h01) begin
        core_next.ctrl[CTRL_RST_BIT] = 1'b0;  // R19
        core_next.core_rst = 1'b0;
      end
    end else if (wr_tgl_core != core_reg.wr_seen) begin
      core_next.wr_seen = wr_tgl_core;
      if (link_reg.wr_data[CTRL_RST_BIT]) begin
        // register returns to its default while the count runs
        core_next.ctrl = CTRL_RESET_VAL;  // R5
        core_next.ctrl[CTRL_RST_BIT] = 1'b1;  // R5
        core_next.rst_cnt  = CORE_RST_CYC;  // R5
        core_next.core_rst = 1'b1;  // R5
      end else begin
        // reserved bits are stored as written
        core_next.ctrl = link_reg.wr_data;  // R2
      end
    end
    // during the self-reset the rate falls back with the register
    core_next.speed = {core_next.ctrl[SPEED_MSB_BIT],
      core_next.ctrl[SPEED_LSB_BIT]};  // R6
    // publish a copy to the link side whenever it differs, but not
    // while a self-reset runs: the word changes twice in one short
    // span, and two flips of the toggle while mdc is stopped would
    // cancel out and leave the link with a stale copy. a read in that
    // span therefore still shows the word from before the reset
    if ((core_reg.snap != core_reg.ctrl)
        && (core_reg.rst_cnt == 8'h00)) begin
      core_next.snap     = core_reg.ctrl;  // R3
      core_next.snap_tgl = ~core_reg.snap_tgl;
    end
  end

  // core state; the register comes up at its default word
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      core_reg      <= '0;
      core_reg.ctrl <= CTRL_RESET_VAL;
      core_reg.snap <= CTRL_RESET_VAL;
      // the rate comes up with the default word, 1000 Mb/s
      core_reg.speed <= {CTRL_RESET_VAL[SPEED_MSB_BIT],
        CTRL_RESET_VAL[SPEED_LSB_BIT]};
    end else begin
      core_reg <= core_next;
    end
  end

  // the rate code steers the clock muxes straight from its register
  assign speed_code = core_reg.speed;

  // ------------------------------------------------------------------
  // transmit clocking
  // ------------------------------------------------------------------
  // the dividers run from the free-running clock, so the chosen rate
  // is present even while the link clock is stopped between frames
  mlr_txclk #(
    .EXT_CLK  (EXT_CLK),
    .TXC_SKEW (TXC_SKEW)
  ) u_txclk (
    .core_clk     (core_clk),
    .reset        (reset),
    .speed_sel    (speed_code),
    .ext_gmii_clk (ext_gmii_clk),
    .gmii_tx_clk  (gmii_tx_clk),
    .rgmii_txc    (rgmii_txc)
  );

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // each output below but gmii_rx_clk is a register of its own domain: the line pair
  // of mdc, the rate and the self-reset of core_clk
  assign mdio_out    = link_reg.pin.mdio_out;
  assign mdio_oe     = link_reg.pin.mdio_oe;
  assign speed_mode  = core_reg.speed;  // R6
  assign core_reset  = core_reg.core_rst;  // R5
  // clocks cannot pass a flop; the receive clock is forwarded as is
  assign gmii_rx_clk = rgmii_rxc;  // R12
endmodule
`default_nettype wire

// file: mlr_pkg.sv
// package: constants, states and state records of the line-rate control block
`default_nettype none
package mlr_pkg;
  // ------------------------------------------------------------------
  // register map and field layout
  // ------------------------------------------------------------------
  localparam logic [4:0]  CTRL_REG_ADDR  = 5'h10;
  localparam int          CTRL_RST_BIT   = 15;
  localparam int          SPEED_MSB_BIT  = 6;
  localparam int          SPEED_LSB_BIT  = 13;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h0040;
  localparam logic [4:0]  PHY_ADDR_DEF   = 5'h01;
  localparam logic [4:0]  PHY_ADDR_PHY   = 5'h00;

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam logic [5:0]  PRE_ONES       = 6'h20;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [4:0]  OP_BITS        = 5'h02;
  localparam logic [4:0]  ADDR_BITS      = 5'h0A;
  localparam logic [4:0]  TA_BITS        = 5'h02;
  localparam logic [4:0]  DATA_BITS      = 5'h10;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int          CORE_CLK_HZ    = 50_000_000;
  localparam int          CORE_CLK_NS    = 20;
  localparam int          CORE_RST_NS    = 1000;
  localparam logic [7:0]  CORE_RST_CYC   =
    8'((CORE_RST_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
  localparam int          F_2M5_HZ       = 2_500_000;
  localparam int          F_25M_HZ       = 25_000_000;
  localparam int          F_125M_HZ      = 125_000_000;
  localparam int          HALF_2M5       = CORE_CLK_HZ / (2 * F_2M5_HZ);
  localparam int          HALF_25M       = CORE_CLK_HZ / (2 * F_25M_HZ);
  localparam int          HALF_125M      = CORE_CLK_HZ / (2 * F_125M_HZ);
  localparam logic [1:0]  SKEW_NONE      = 2'h0;
  localparam logic [1:0]  SKEW_DELAY     = 2'h1;
  localparam logic [1:0]  SKEW_QUAD      = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    MLR_PRE  = 3'b000,
    MLR_ST   = 3'b001,
    MLR_OP   = 3'b011,
    MLR_ADDR = 3'b010,
    MLR_TA   = 3'b110,
    MLR_DATA = 3'b111
  } mlr_frame_e;

  typedef struct packed {
    logic       mdio_out;
    logic       mdio_oe;
  } mlr_mdio_s;

  typedef struct packed {
    mlr_frame_e st;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [1:0] op;
    logic [9:0] addr;
    logic       hit;
    logic [15:0] sh;
    logic [15:0] wr_data;
    logic       wr_tgl;
    logic       rd_seen;
    logic [15:0] rd_word;
    mlr_mdio_s  pin;
  } mlr_link_s;

  typedef struct packed {
    logic [15:0] ctrl;
    logic        wr_seen;
    logic [7:0]  rst_cnt;
    logic        core_rst;
    logic [1:0]  speed;
    logic [15:0] snap;
    logic        snap_tgl;
  } mlr_core_s;

  typedef struct packed {
    logic [2:0][7:0] cnt;
    logic [2:0]      clk;
    logic [2:0]      quad;
    logic            sel;
    logic            sel_q;
    logic            dly;
    logic            txc;
  } mlr_clk_s;
endpackage
`default_nettype wire

// file: mlr_sync.sv
// module: three-stage synchroniser whose output moves when stages 2 and 3 agree
`default_nettype none
module mlr_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic din,
  output var  logic dout
);
  import mlr_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } mlr_sync_s;

  mlr_sync_s state_reg;
  mlr_sync_s state_next;

  // ------------------------------------------------------------------
  // chain; stage 1 feeds only stage 2
  // ------------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    state_next.s1  = din;
    state_next.s2  = state_reg.s1;
    state_next.s3  = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      state_next.out = state_reg.s3;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.out;
endmodule
`default_nettype wire

// file: mlr_txclk.sv
// module: transmit clock generation, cascaded selection and txc skew
`default_nettype none
module mlr_txclk #(
  parameter bit         EXT_CLK  = 1'b0,
  parameter logic [1:0] TXC_SKEW = 2'h0
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [1:0] speed_sel,
  input  wire logic       ext_gmii_clk,
  output var  logic       gmii_tx_clk,
  output var  logic       rgmii_txc
);
  import mlr_pkg::*;

  // half periods per rate; a rate above core_clk/2 clamps to one cycle,
  // so with a slow reference the gigabit clock runs slower than nominal
  localparam logic [2:0][7:0] HALF = {
    8'((HALF_125M < 1) ? 1 : HALF_125M),
    8'((HALF_25M  < 1) ? 1 : HALF_25M),
    8'((HALF_2M5  < 1) ? 1 : HALF_2M5)
  };

  mlr_clk_s state_reg;
  mlr_clk_s state_next;
  logic     mux0;

  // ------------------------------------------------------------------
  // dividers, muxes and output stage
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // one divider per rate, each with a copy a quarter period plus one cycle late at 2.5, half a period late at 25 and 125
    for (int i = 0; i < 3; i++) begin  // R8
      if (state_reg.cnt[i] == HALF[i] - 8'h01) begin
        state_next.cnt[i] = 8'h00;
        state_next.clk[i] = ~state_reg.clk[i];
      end else begin
        state_next.cnt[i] = state_reg.cnt[i] + 8'h01;
      end
      if (state_reg.cnt[i] == (HALF[i] >> 1)) begin
        state_next.quad[i] = state_reg.clk[i];  // R15
      end
    end
    // cascade: bit 0 picks 2.5 or 25, bit 1 then picks 125
    mux0 = speed_sel[0] ? state_reg.clk[1] : state_reg.clk[0];  // R9
    state_next.sel = speed_sel[1] ? state_reg.clk[2] : mux0;  // R9
    state_next.sel_q = speed_sel[1] ? state_reg.quad[2] :
      (speed_sel[0] ? state_reg.quad[1] : state_reg.quad[0]);
    state_next.dly = state_reg.sel;  // R14
    // output cell drives 1 then 0 per period: a copy of its clock
    if (TXC_SKEW == SKEW_DELAY) begin
      state_next.txc = state_reg.dly;  // R14
    end else if (TXC_SKEW == SKEW_QUAD) begin
      state_next.txc = state_reg.sel_q;  // R15
    end else begin
      state_next.txc = state_reg.sel;  // R13
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // an external clock is used as it comes; the source must match rate
  assign gmii_tx_clk = EXT_CLK ? ext_gmii_clk : state_reg.sel;  // R11
  assign rgmii_txc   = state_reg.txc;  // R13
endmodule
`default_nettype wire

// file: mlr_props.sv
// checker: timing relations at the ports of the line-rate control block
`default_nettype none
module mlr_props
  import mlr_pkg::*;
#(
  parameter logic [1:0] TXC_SKEW = SKEW_NONE
) (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       mdc,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic [1:0] speed_mode,
  input wire logic       core_reset,
  input wire logic       gmii_tx_clk,
  input wire logic       rgmii_txc,
  input wire logic       rgmii_rxc,
  input wire logic       gmii_rx_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------------
  logic [7:0] rst_run_reg;
  logic [4:0] oe_run_reg;
  // lengths of the self-reset pulse and of the driven stretch of a read
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) rst_run_reg <= 8'h00;
    else rst_run_reg <= core_reset ? rst_run_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge mdc or posedge reset) begin
    if (reset) oe_run_reg <= 5'h00;
    else oe_run_reg <= mdio_oe ? oe_run_reg + 5'h01 : 5'h00;
  end

  // ------------------------------------------------------------------
  // core clock domain
  // ------------------------------------------------------------------
  a_rst_length : assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(core_reset) |-> rst_run_reg == CORE_RST_CYC)
    else $error("self reset pulse has the wrong length");
  a_rst_restore : assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(core_reset) |-> speed_mode == 2'h2)
    else $error("speed not restored after self reset");
  a_reset_value : assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(reset) |-> speed_mode == 2'h2 && !core_reset)
    else $error("wrong state after reset release");
  a_txc_follow : assert property (
    @(posedge core_clk) disable iff (reset)
    TXC_SKEW != SKEW_NONE || rgmii_txc == $past(gmii_tx_clk))
    else $error("txc does not trail the transmit clock");
  a_txc_delay : assert property (
    @(posedge core_clk) disable iff (reset)
    TXC_SKEW != SKEW_DELAY || rgmii_txc == $past(gmii_tx_clk, 2))
    else $error("delayed txc does not trail by two cycles");
  // 24 cycles of settled speed keep the mux switch-over out of view
  a_slow_clock : assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(gmii_tx_clk) && speed_mode == 2'h0
      && $past(speed_mode, 24) == 2'h0 |-> gmii_tx_clk [*8])
    else $error("10 Mb/s clock high phase too short");
  a_fast_clock : assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(gmii_tx_clk) && speed_mode != 2'h0
      && $past(speed_mode, 24) == speed_mode |=> !gmii_tx_clk)
    else $error("fast clock high phase too long");
  a_rx_forward : assert property (
    @(posedge core_clk) disable iff (reset) gmii_rx_clk == rgmii_rxc)
    else $error("receive clock not forwarded");

  // ------------------------------------------------------------------
  // link clock domain
  // ------------------------------------------------------------------
  a_turn_low : assert property (
    @(posedge mdc) disable iff (reset) $rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not low");
  a_read_span : assert property (
    @(posedge mdc) disable iff (reset)
    $fell(mdio_oe) |-> oe_run_reg == 5'h11)
    else $error("read drive span not 17 bits");
  a_quiet_line : assert property (
    @(posedge mdc) disable iff (reset) !mdio_oe |-> !mdio_out)
    else $error("data driven while not enabled");

  c_read : cover property (@(posedge mdc) $rose(mdio_oe));
  c_self_rst : cover property (@(posedge core_clk) $rose(core_reset));
  c_slow : cover property (@(posedge core_clk) speed_mode == 2'h0);
endmodule

bind mlr_top mlr_props #(.TXC_SKEW(TXC_SKEW)) u_mlr_props (
  .core_clk(core_clk), .reset(reset), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .speed_mode(speed_mode), .core_reset(core_reset),
  .gmii_tx_clk(gmii_tx_clk), .rgmii_txc(rgmii_txc),
  .rgmii_rxc(rgmii_rxc), .gmii_rx_clk(gmii_rx_clk)
);
`default_nettype wire

// file: mlr_mac_model.sv
// station model: drives mdc and the data line one frame at a time
`default_nettype none
module mlr_mac_model (
  output var  logic mdc,
  output var  logic mac_out,
  output var  logic mac_oe,
  input  wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc = 1'b0;
    mac_out = 1'b1;
    mac_oe = 1'b0;
  end
  // mdc runs only inside a frame; bits move while mdc is low
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] w;
    w = {32'hFFFF_FFFF, 2'h1, op, phy, ra, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      mac_oe = !(op == 2'h2 && i < 18);
      mac_out = w[i];
      #40;
      if (i < 16) rd[i] = line;
      mdc = 1'b1;
      #40;
      mdc = 1'b0;
    end
    mac_oe = 1'b0; // line falls back to its pull-up
  endtask
endmodule
`default_nettype wire

// file: test_mdio_line_rate_control.sv
// testbench: control register access over management frames
`default_nettype none
module test_mdio_line_rate_control;
  timeunit 1ns;
  timeprecision 1ps;
  import mlr_pkg::*;
  localparam logic [4:0] ADDR = 5'h03;
  logic        core_clk, reset, rgmii_rxc, mdc, mac_out, mac_oe, line;
  logic        mdio_out, mdio_oe, core_reset, gmii_tx_clk, rgmii_txc;
  logic        gmii_rx_clk;
  logic [1:0]  speed_mode;
  logic [15:0] rd;
  logic [15:0] codes [4] = '{16'h0000, 16'h2040, 16'h0040, 16'h2000};
  int          bad_count, comparisons;

  always #10 core_clk = !core_clk;
  always #4 rgmii_rxc = !rgmii_rxc;
  // pulled-up wire shared by station and block
  assign line = mac_oe ? mac_out : (mdio_oe ? mdio_out : 1'b1);

  mlr_top #(.PHY_ADDR(ADDR)) u_mlr_top (
    .core_clk(core_clk), .reset(reset), .mdc(mdc), .mdio_in(line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .speed_mode(speed_mode),
    .core_reset(core_reset), .ext_gmii_clk(1'b0),
    .gmii_tx_clk(gmii_tx_clk), .rgmii_txc(rgmii_txc),
    .rgmii_rxc(rgmii_rxc), .gmii_rx_clk(gmii_rx_clk)
  );
  mlr_mac_model u_mlr_mac_model (
    .mdc(mdc), .mac_out(mac_out), .mac_oe(mac_oe), .line(line)
  );
  // second block on the same line, never addressed: its txc runs
  // through the delay stage, which the bound checker times
  mlr_top #(.PHY_ADDR(5'h05), .TXC_SKEW(SKEW_DELAY)) u_mlr_top_dly (
    .core_clk(core_clk), .reset(reset), .mdc(mdc), .mdio_in(line),
    .mdio_out(), .mdio_oe(), .speed_mode(), .core_reset(),
    .ext_gmii_clk(1'b0), .gmii_tx_clk(), .rgmii_txc(),
    .rgmii_rxc(rgmii_rxc), .gmii_rx_clk()
  );

  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // write frame, then room for the crossing into the core domain
  task automatic wr(input logic [1:0] op, input logic [4:0] phy,
                    input logic [4:0] ra, input logic [15:0] wd,
                    input logic [1:0] exp);
    u_mlr_mac_model.frame(op, phy, ra, wd, rd);
    repeat (20) @(posedge core_clk);
    chk("speed_mode", {14'h0, exp}, {14'h0, speed_mode});
  endtask
  task automatic rdc(input logic [4:0] phy, input logic [4:0] ra,
                     input logic [15:0] exp);
    u_mlr_mac_model.frame(2'h2, phy, ra, 16'h0000, rd);
    chk("read word", exp, rd);
  endtask

  initial begin
    core_clk = 1'b0;
    rgmii_rxc = 1'b0;
    reset = 1'b1;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    #2 reset = 1'b0;
    @(posedge core_clk);
    #2 chk("speed_mode", 16'h0002, {14'h0, speed_mode});
    rdc(ADDR, CTRL_REG_ADDR, CTRL_RESET_VAL);
    // every speed code, the reserved one too
    foreach (codes[k]) begin
      wr(OP_WRITE, ADDR, CTRL_REG_ADDR, codes[k],
         {codes[k][6], codes[k][13]});
      rdc(ADDR, CTRL_REG_ADDR, codes[k]);
    end
    // self reset: other bits of the word are thrown away
    u_mlr_mac_model.frame(OP_WRITE, ADDR, CTRL_REG_ADDR, 16'hA000, rd);
    for (int n = 0; n < 20 && core_reset !== 1'b1; n++)
      @(posedge core_clk);
    chk("core_reset", 16'h0001, {15'h0, core_reset});
    repeat (60) @(posedge core_clk);
    chk("core_reset", 16'h0000, {15'h0, core_reset});
    chk("speed_mode", 16'h0002, {14'h0, speed_mode});
    rdc(ADDR, CTRL_REG_ADDR, CTRL_RESET_VAL);
    // frames that must be ignored: reads see the pull-up, writes leave the rate alone
    rdc(5'h00, CTRL_REG_ADDR, 16'hFFFF);
    rdc(ADDR, 5'h0F, 16'hFFFF);
    wr(OP_WRITE, 5'h00, CTRL_REG_ADDR, 16'h0000, 2'h2);
    wr(OP_WRITE, 5'h04, CTRL_REG_ADDR, 16'h0000, 2'h2);
    wr(OP_WRITE, ADDR, 5'h11, 16'h0000, 2'h2);
    wr(2'h3, ADDR, CTRL_REG_ADDR, 16'h0000, 2'h2);
    wr(2'h0, ADDR, CTRL_REG_ADDR, 16'h0000, 2'h2);
    finish_test;
  end

  // watchdog: the whole sequence needs well under 200 us
  initial begin
    #500us;
    bad_count++;
    finish_test;
  end
endmodule
`default_nettype wire
